// >>> rtl/uart_frac_pkg.sv
// Constants for the fractional-baud serial unit with DMA channel pair.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package uart_frac_pkg;
	localparam logic [7:0] OFS_DATA     = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h04;
	localparam logic [7:0] OFS_IRQ_ID   = 8'h08;
	localparam logic [7:0] OFS_LINE_CTL = 8'h0C;
	localparam logic [7:0] OFS_LINE_ST  = 8'h14;
	localparam logic [7:0] OFS_DIVISOR  = 8'h20;
	localparam logic [7:0] OFS_FRACTION = 8'h24;
	localparam logic [7:0] OFS_GAP      = 8'h2C;
	localparam logic [7:0] OFS_TXD_ADDR = 8'h30;
	localparam logic [7:0] OFS_TXD_CNT  = 8'h34;
	localparam logic [7:0] OFS_RXD_ADDR = 8'h38;
	localparam logic [7:0] OFS_RXD_CNT  = 8'h3C;
	localparam logic [7:0] OFS_DMA_CTL  = 8'h40;
	localparam logic [7:0]  FRACTION_RST = 8'h00;
	localparam logic [15:0] DIVISOR_RST  = 16'h0001;
	localparam logic [7:0]  LINE_CTL_RST = 8'h03;
	localparam logic [7:0]  GAP_RST      = 8'h00;
	// Line control field positions
	localparam int LC_DLEN   = 0;
	localparam int LC_STOP   = 2;
	localparam int LC_PEN    = 3;
	localparam int LC_PTYPE  = 4;
	localparam int LC_STICK  = 5;
	// Interrupt enable / status bit positions
	localparam int IB_RXRDY  = 0;
	localparam int IB_HOLD   = 1;
	localparam int IB_LINE   = 2;
	localparam int IB_SHIFT  = 3;
	localparam int IB_DMATX  = 4;
	localparam int IB_DMARX  = 5;
	localparam int OVERSAMPLE  = 16;
	localparam int SAMPLE_TICK = 7;
endpackage : uart_frac_pkg

// >>> rtl/uart_baud_gen.sv
// Baud tick generator with fractional divisor compensation.
// Assumes divisor and fraction come from registers in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Settings
	input  wire logic [15:0] baud_divisor,
	input  wire logic [7:0]  baud_fraction_value,
	// Oversample tick
	output logic             tick
);
	logic [15:0] cnt_r;
	logic [7:0]  fraction_step_r;
	logic        stretch_r;
	logic [8:0]  acc_sum;
	logic [16:0] period_len;
	logic        period_end;

	// Stretch by one only in the period after an overflow
	assign period_len = {1'b0, baud_divisor} + {16'h0000, stretch_r};
	assign period_end = ({1'b0, cnt_r} + 17'h0_0001) >= period_len;
	assign acc_sum    = {1'b0, fraction_step_r} + {1'b0, baud_fraction_value};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r           <= 16'h0000;
			fraction_step_r <= 8'h00;
			stretch_r       <= 1'b0;
			tick            <= 1'b0;
		end else begin
			tick <= period_end;
			if (period_end) begin
				cnt_r           <= 16'h0000;
				fraction_step_r <= acc_sum[7:0];
				stretch_r       <= (baud_fraction_value != 8'h00) && acc_sum[8];
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule : uart_baud_gen
`default_nettype wire

// >>> rtl/uart_frac_dma.sv
// Serial transmitter, receiver, APB registers and DMA channel pair.
// Assumes an APB master and a DMA bus master with a simple req/ack.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_frac_dma (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial lines
	input  wire logic        rxd,
	output logic             txd,
	// DMA memory port
	output logic             dma_req,
	output logic             dma_write,
	output logic [31:0]      dma_addr,
	output logic [7:0]       dma_wdata,
	input  wire logic        dma_ack,
	input  wire logic [7:0]  dma_rdata,
	// Interrupt level
	output logic             irq
);
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GAP} tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
	typedef enum {DM_IDLE, DM_TXRD, DM_RXWR} dma_state_t;

	logic [15:0] baud_divisor_r;
	logic [7:0]  baud_fraction_value_r, line_control_r, interframe_delay_r, irq_enable_r;
	logic [31:0] txd_addr_r, rxd_addr_r;
	logic [15:0] txd_cnt_r, rxd_cnt_r;
	logic [1:0]  dma_en_r;
	logic [7:0]  hold_r, rx_hold_r;
	logic        hold_full_r, rx_ready_r;
	logic        overrun_r, frame_err_r, parity_err_r, break_r;
	logic        dma_tx_done_flag_r, dma_rx_done_flag_r;
	logic        tick;
	tx_state_t   tx_st_r;
	rx_state_t   rx_st_r;
	dma_state_t  dm_st_r;
	logic [3:0]  tx_sub_r, rx_sub_r;
	logic [7:0]  tx_sh_r, rx_sh_r, tx_bits_r;
	logic [2:0]  tx_idx_r, rx_idx_r;
	logic        rx_s1_r, rx_s2_r, rx_s3_r;

	// Decode
	logic        wr_en, rd_en, tx_bit_end, rx_mid, rx_bit_end;
	logic [2:0]  data_last;
	logic        par_bit, rx_par_exp, rx_fall, line_err_any, hold_write_cpu, rx_read_cpu;
	logic        tx_load, rx_done_char, dm_txrd_ok, dm_rxwr_ok;
	logic [5:0]  irq_status;
	logic [31:0] rd_mux;
	logic        addr_ok;

	assign wr_en          = psel && penable && pwrite;
	assign rd_en          = psel && penable && !pwrite;
	assign hold_write_cpu = wr_en && paddr == uart_frac_pkg::OFS_DATA;
	assign rx_read_cpu    = rd_en && paddr == uart_frac_pkg::OFS_DATA;
	assign data_last      = 3'd4 + {1'b0, line_control_r[uart_frac_pkg::LC_DLEN +: 2]};
	assign tx_bit_end     = tick && tx_sub_r == 4'hF;
	assign rx_mid         = tick && rx_sub_r == 4'(uart_frac_pkg::SAMPLE_TICK - 1);
	assign rx_bit_end     = tick && rx_sub_r == 4'hF;
	assign rx_fall        = rx_s3_r && !rx_s2_r;

	// Parity: odd, even, forced one, forced zero
	function automatic logic parity_of(input logic [7:0] d, input logic [2:0] last,
		input logic ptype, input logic stick);
		logic [7:0] m;
		m = 8'hFF >> (3'd7 - last);
		if (stick)
			parity_of = !ptype;
		else
			parity_of = ^(d & m) ^ !ptype;
	endfunction : parity_of

	assign par_bit    = parity_of(tx_bits_r, data_last, line_control_r[uart_frac_pkg::LC_PTYPE],
		line_control_r[uart_frac_pkg::LC_STICK]);
	assign rx_par_exp = parity_of(rx_sh_r, data_last, line_control_r[uart_frac_pkg::LC_PTYPE],
		line_control_r[uart_frac_pkg::LC_STICK]);
	assign tx_load      = hold_full_r && (tx_st_r == TX_IDLE);
	assign rx_done_char = rx_st_r == RX_STOP && rx_mid;
	assign line_err_any = overrun_r | frame_err_r | parity_err_r | break_r;
	assign irq_status   = {dma_rx_done_flag_r, dma_tx_done_flag_r, tx_st_r == TX_IDLE && !hold_full_r,
		line_err_any, !hold_full_r, rx_ready_r};
	assign dm_txrd_ok   = dm_st_r == DM_TXRD && dma_ack;
	assign dm_rxwr_ok   = dm_st_r == DM_RXWR && dma_ack;

	assign addr_ok = paddr inside {uart_frac_pkg::OFS_DATA, uart_frac_pkg::OFS_IRQ_EN,
		uart_frac_pkg::OFS_IRQ_ID, uart_frac_pkg::OFS_LINE_CTL, uart_frac_pkg::OFS_LINE_ST,
		uart_frac_pkg::OFS_DIVISOR, uart_frac_pkg::OFS_FRACTION, uart_frac_pkg::OFS_GAP,
		uart_frac_pkg::OFS_TXD_ADDR, uart_frac_pkg::OFS_TXD_CNT, uart_frac_pkg::OFS_RXD_ADDR,
		uart_frac_pkg::OFS_RXD_CNT, uart_frac_pkg::OFS_DMA_CTL};

	always_comb begin
		case (paddr)
			uart_frac_pkg::OFS_DATA:     rd_mux = {24'h00_0000, rx_hold_r};
			uart_frac_pkg::OFS_IRQ_EN:   rd_mux = {24'h00_0000, irq_enable_r};
			uart_frac_pkg::OFS_IRQ_ID:   rd_mux = {26'h000_0000, irq_status};
			uart_frac_pkg::OFS_LINE_CTL: rd_mux = {24'h00_0000, line_control_r};
			uart_frac_pkg::OFS_LINE_ST:  rd_mux = {25'h000_0000, irq_status[3], !hold_full_r,
				break_r, frame_err_r, parity_err_r, overrun_r, rx_ready_r};
			uart_frac_pkg::OFS_DIVISOR:  rd_mux = {16'h0000, baud_divisor_r};
			uart_frac_pkg::OFS_FRACTION: rd_mux = {24'h00_0000, baud_fraction_value_r};
			uart_frac_pkg::OFS_GAP:      rd_mux = {24'h00_0000, interframe_delay_r};
			uart_frac_pkg::OFS_TXD_ADDR: rd_mux = txd_addr_r;
			uart_frac_pkg::OFS_TXD_CNT:  rd_mux = {16'h0000, txd_cnt_r};
			uart_frac_pkg::OFS_RXD_ADDR: rd_mux = rxd_addr_r;
			uart_frac_pkg::OFS_RXD_CNT:  rd_mux = {16'h0000, rxd_cnt_r};
			uart_frac_pkg::OFS_DMA_CTL:  rd_mux = {30'h0000_0000, dma_en_r};
			default:                     rd_mux = 32'h0000_0000;
		endcase
	end

	uart_baud_gen u_baud (
		.pclk                (pclk),
		.presetn             (presetn),
		.baud_divisor        (baud_divisor_r),
		.baud_fraction_value (baud_fraction_value_r),
		.tick                (tick)
	);

	// APB registers and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor_r        <= uart_frac_pkg::DIVISOR_RST;
			baud_fraction_value_r <= uart_frac_pkg::FRACTION_RST;
			line_control_r        <= uart_frac_pkg::LINE_CTL_RST;
			interframe_delay_r    <= uart_frac_pkg::GAP_RST;
			irq_enable_r          <= 8'h00;
			dma_en_r              <= 2'b00;
			prdata                <= 32'h0000_0000;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			irq                   <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
			irq     <= |(irq_status & irq_enable_r[5:0]);
			if (wr_en && pready) begin
				case (paddr)
					uart_frac_pkg::OFS_IRQ_EN:   irq_enable_r          <= pwdata[7:0];
					uart_frac_pkg::OFS_LINE_CTL: line_control_r        <= pwdata[7:0];
					uart_frac_pkg::OFS_DIVISOR:  baud_divisor_r        <= pwdata[15:0];
					uart_frac_pkg::OFS_FRACTION: baud_fraction_value_r <= pwdata[7:0];
					uart_frac_pkg::OFS_GAP:      interframe_delay_r    <= pwdata[7:0];
					uart_frac_pkg::OFS_DMA_CTL:  dma_en_r              <= pwdata[1:0];
					default:                     dma_en_r              <= dma_en_r;
				endcase
			end
		end
	end

	// Holding registers, status flags, DMA channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= 8'h00; hold_full_r <= 1'b0; rx_hold_r <= 8'h00; rx_ready_r <= 1'b0;
			overrun_r <= 1'b0; frame_err_r <= 1'b0; parity_err_r <= 1'b0; break_r <= 1'b0;
			txd_addr_r <= 32'h0000_0000; rxd_addr_r <= 32'h0000_0000;
			txd_cnt_r <= 16'h0000; rxd_cnt_r <= 16'h0000;
			dma_tx_done_flag_r <= 1'b0; dma_rx_done_flag_r <= 1'b0;
			dm_st_r <= DM_IDLE;
		end else begin
			// Single holding register each way
			if (hold_write_cpu && pready) begin
				hold_r <= pwdata[7:0];
				hold_full_r <= 1'b1;
			end else if (dm_txrd_ok) begin
				hold_r <= dma_rdata;
				hold_full_r <= 1'b1;
			end else if (tx_load)
				hold_full_r <= 1'b0;
			if (rx_done_char) begin
				rx_hold_r <= rx_sh_r;
				rx_ready_r <= 1'b1;
				overrun_r <= rx_ready_r;
				frame_err_r <= !rx_s2_r;
				break_r <= !rx_s2_r && rx_sh_r == 8'h00;
			end else if ((rx_read_cpu && pready) || dm_rxwr_ok) begin
				rx_ready_r <= 1'b0;
			end
			if (rx_st_r == RX_PAR && rx_mid)
				parity_err_r <= rx_s2_r != rx_par_exp;
			else if (rd_en && pready && paddr == uart_frac_pkg::OFS_LINE_ST) begin
				overrun_r <= rx_done_char ? rx_ready_r : 1'b0;
				parity_err_r <= 1'b0;
				frame_err_r <= rx_done_char ? !rx_s2_r : 1'b0;
				break_r <= rx_done_char ? (!rx_s2_r && rx_sh_r == 8'h00) : 1'b0;
			end
			// DMA channel registers
			if (wr_en && pready && paddr == uart_frac_pkg::OFS_TXD_ADDR) txd_addr_r <= pwdata;
			if (wr_en && pready && paddr == uart_frac_pkg::OFS_RXD_ADDR) rxd_addr_r <= pwdata;
			if (wr_en && pready && paddr == uart_frac_pkg::OFS_TXD_CNT) txd_cnt_r <= pwdata[15:0];
			else if (dm_txrd_ok) txd_cnt_r <= txd_cnt_r - 16'h0001;
			if (wr_en && pready && paddr == uart_frac_pkg::OFS_RXD_CNT) rxd_cnt_r <= pwdata[15:0];
			else if (dm_rxwr_ok) rxd_cnt_r <= rxd_cnt_r - 16'h0001;
			// Done once last byte reaches holding register / memory
			if (dm_txrd_ok && txd_cnt_r == 16'h0001) dma_tx_done_flag_r <= 1'b1;
			else if (wr_en && pready && paddr == uart_frac_pkg::OFS_IRQ_ID && pwdata[uart_frac_pkg::IB_DMATX])
				dma_tx_done_flag_r <= 1'b0;
			if (dm_rxwr_ok && rxd_cnt_r == 16'h0001) dma_rx_done_flag_r <= 1'b1;
			else if (wr_en && pready && paddr == uart_frac_pkg::OFS_IRQ_ID && pwdata[uart_frac_pkg::IB_DMARX])
				dma_rx_done_flag_r <= 1'b0;
			case (dm_st_r)
				DM_IDLE: begin
					if (dma_en_r[1] && rx_ready_r && !rx_done_char && rxd_cnt_r != 16'h0000)
						dm_st_r <= DM_RXWR;
					else if (dma_en_r[0] && !hold_full_r && txd_cnt_r != 16'h0000)
						dm_st_r <= DM_TXRD;
				end
				DM_TXRD: if (dma_ack) dm_st_r <= DM_IDLE;
				DM_RXWR: if (dma_ack) dm_st_r <= DM_IDLE;
				default: dm_st_r <= DM_IDLE;
			endcase
		end
	end

	// DMA bus outputs and address advance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req <= 1'b0; dma_write <= 1'b0; dma_addr <= 32'h0000_0000; dma_wdata <= 8'h00;
		end else begin
			dma_req   <= (dm_st_r != DM_IDLE) && !dma_ack;
			dma_write <= dm_st_r == DM_RXWR;
			dma_addr  <= (dm_st_r == DM_RXWR) ? rxd_addr_r + {16'h0000, rxd_cnt_r} :
				txd_addr_r + {16'h0000, txd_cnt_r};
			dma_wdata <= rx_hold_r;
		end
	end

	// Transmitter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r <= TX_IDLE; tx_sub_r <= 4'h0; tx_sh_r <= 8'h00; tx_bits_r <= 8'h00;
			tx_idx_r <= 3'd0; txd <= 1'b1;
		end else begin
			if (tick) tx_sub_r <= tx_sub_r + 4'h1;
			case (tx_st_r)
				TX_IDLE: begin
					txd <= 1'b1;
					if (tx_load) begin
						tx_sh_r <= hold_r; tx_bits_r <= hold_r; tx_sub_r <= 4'h0; tx_st_r <= TX_START;
						txd <= 1'b0;
					end
				end
				TX_START: if (tx_bit_end) begin
					tx_st_r <= TX_DATA; tx_idx_r <= 3'd0; txd <= tx_sh_r[0];
				end
				TX_DATA: if (tx_bit_end) begin
					tx_sh_r <= tx_sh_r >> 1; tx_idx_r <= (tx_idx_r == data_last) ? 3'd0 : tx_idx_r + 3'd1;
					if (tx_idx_r == data_last) begin
						tx_st_r <= line_control_r[uart_frac_pkg::LC_PEN] ? TX_PAR : TX_STOP;
						txd <= line_control_r[uart_frac_pkg::LC_PEN] ? par_bit : 1'b1;
					end else
						txd <= tx_sh_r[1];
				end
				TX_PAR: if (tx_bit_end) begin
					tx_st_r <= TX_STOP; tx_idx_r <= 3'd0; txd <= 1'b1;
				end
				TX_STOP: if (tx_bit_end) begin
					tx_idx_r <= tx_idx_r + 3'd1;
					if (tx_idx_r >= {2'b00, line_control_r[uart_frac_pkg::LC_STOP]}) begin
						tx_idx_r <= 3'd0; tx_bits_r <= 8'h01;
						tx_st_r <= interframe_delay_r == 8'h00 ? TX_IDLE : TX_GAP;
					end
				end
				TX_GAP: if (tx_bit_end) begin
					txd <= 1'b1; tx_bits_r <= tx_bits_r + 8'h01;
					if (tx_bits_r >= interframe_delay_r) tx_st_r <= TX_IDLE;
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// Receiver
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_r <= 1'b1; rx_s2_r <= 1'b1; rx_s3_r <= 1'b1;
			rx_st_r <= RX_IDLE; rx_sub_r <= 4'h0; rx_sh_r <= 8'h00; rx_idx_r <= 3'd0;
		end else begin
			rx_s1_r <= rxd; rx_s2_r <= rx_s1_r; rx_s3_r <= rx_s2_r;
			if (tick) rx_sub_r <= rx_sub_r + 4'h1;
			case (rx_st_r)
				RX_IDLE: if (rx_fall) begin
					rx_st_r <= RX_START; rx_sub_r <= 4'h0; rx_sh_r <= 8'h00;
				end
				RX_START: if (rx_mid && rx_s2_r) rx_st_r <= RX_IDLE;
					else if (rx_bit_end) begin rx_st_r <= RX_DATA; rx_idx_r <= 3'd0; end
				RX_DATA: begin
					if (rx_mid) rx_sh_r[rx_idx_r] <= rx_s2_r;
					if (rx_bit_end) begin
						rx_idx_r <= rx_idx_r + 3'd1;
						if (rx_idx_r == data_last)
							rx_st_r <= line_control_r[uart_frac_pkg::LC_PEN] ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rx_bit_end) rx_st_r <= RX_STOP;
				RX_STOP: if (rx_mid) rx_st_r <= RX_IDLE;
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end
endmodule : uart_frac_dma
`default_nettype wire

// >>> verif/uart_frac_dma_chk.sv
// Port checker for the serial unit: register bus, DMA handshake, tx start bit.
// Assumes it is bound to uart_frac_dma and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uart_frac_dma_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Serial and DMA
	input wire logic        txd,
	input wire logic        dma_req,
	input wire logic        dma_write,
	input wire logic [31:0] dma_addr,
	input wire logic        dma_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_start_low;
		!txd [*8];
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_err_unmapped: assert property (s_setup ##0 (paddr == 8'h10) |=> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (s_setup ##0 (paddr == uart_frac_pkg::OFS_FRACTION)
		|=> !pslverr)
		else $error("error on mapped address");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_req_holds: assert property (dma_req && !dma_ack
		|=> dma_req && $stable(dma_addr) && $stable(dma_write))
		else $error("dma request changed before ack");
	a_req_drops: assert property (dma_req && dma_ack |=> !dma_req)
		else $error("dma request kept after ack");
	a_start_bit: assert property ($fell(txd) |-> s_start_low)
		else $error("start bit too short");
endmodule : uart_frac_dma_chk
bind uart_frac_dma uart_frac_dma_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .txd, .dma_req, .dma_write, .dma_addr, .dma_ack);
`default_nettype wire

// >>> verif/remote_serial.sv
// Remote serial device: captures frames on txd, sends frames on rxd.
// Assumes the bench sets bit period in pclk cycles and frame length in bits.
`timescale 1ns/1ps
`default_nettype none
module remote_serial (
	// Clock
	input  wire logic   pclk,
	// Serial lines
	input  wire logic   txd,
	output logic        rxd,
	// Settings
	input  var int      bit_cycles,
	input  var int      nbits,
	// Captured frames
	output logic [11:0] frame_bits,
	output int          frame_start,
	output int          frames
);
	int          cyc = 0;
	logic [11:0] log_q[$];
	initial begin
		rxd = 1'b1;
		frames = 0;
		frame_start = 0;
		frame_bits = 12'h000;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	// Mid-bit sampling from the start edge
	initial forever begin
		wait (txd === 1'b1);
		@(negedge txd);
		frame_start = cyc;
		frame_bits = 12'h000;
		repeat (bit_cycles / 2) @(posedge pclk);
		for (int i = 0; i < nbits; i++) begin
			frame_bits[i] = txd;
			if (i < nbits - 1) repeat (bit_cycles) @(posedge pclk);
		end
		log_q.push_back(frame_bits);
		frames++;
	end
	// Line returns high between frames
	task automatic send(input logic [11:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rxd <= b[i];
			repeat (bit_cycles - 1) @(posedge pclk);
		end
		@(posedge pclk);
		rxd <= 1'b1;
	endtask : send
endmodule : remote_serial
`default_nettype wire

// >>> verif/uart_frac_baud_dma_bench.sv
// Bench for the serial unit: APB tasks, remote serial model, DMA memory.
// Assumes uart_frac_pkg, the design and the remote model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module uart_frac_baud_dma_bench;
	localparam logic [7:0] LCS[5] = '{8'h03, 8'h08, 8'h1E, 8'h2B, 8'h3B};
	localparam logic [7:0] TXB[5] = '{8'hA5, 8'h13, 8'h6E, 8'h5A, 8'hC3};
	localparam int GP[4] = '{0, 3, 0, 0};
	localparam int FR[4] = '{0, 0, 128, 64};
	localparam int BC[4] = '{32, 32, 40, 36};
	localparam logic [7:0] RXB[3] = '{8'h3C, 8'h3C, 8'h55};
	localparam logic [11:0] RXM[3] = '{12'h000, 12'h200, 12'h400};
	localparam logic [31:0] RST[3] = '{32'h61, 32'h65, 32'h69};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, dma_addr, d;
	logic        pready, pslverr, rxd, txd, dma_req, dma_write, irq, dma_ack = 1'b0;
	logic [7:0]  dma_wdata, dma_rdata = 8'h00;
	logic [7:0]  txq[$], rxq[$];
	logic [31:0] aq[$];
	logic [11:0] frame_bits, bits;
	int          bit_cycles = 32, nbits = 10, frame_start, frames, nb, t0, f0;
	int          fail_count = 0, num_checks = 0, cyc = 0, nx = 0, ackd = 0;
	always #4 pclk = ~pclk;
	uart_frac_dma dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .txd, .dma_req, .dma_write, .dma_addr, .dma_wdata,
		.dma_ack, .dma_rdata, .irq);
	remote_serial remote (.pclk, .txd, .rxd, .bit_cycles, .nbits, .frame_bits,
		.frame_start, .frames);
	// Memory answers every other request slowly
	always @(posedge pclk) begin
		dma_ack <= 1'b0;
		if (dma_req && !dma_ack) begin
			ackd <= ackd + 1;
			if (ackd >= (nx % 2) * 4) begin
				ackd <= 0;
				nx <= nx + 1;
				dma_ack <= 1'b1;
				dma_rdata <= 8'h40 + nx[7:0];
				if (dma_write) begin
					rxq.push_back(dma_wdata);
					aq.push_back(dma_addr);
				end else begin
					txq.push_back(8'h40 + nx[7:0]);
				end
			end
		end
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] rd;
		apb(1'b1, a, wd, rd);
	endtask : wr
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] rd;
		apb(1'b0, a, 32'h0000_0000, rd);
		chk(rd & m, exp);
	endtask : rdm
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		d = 32'h0000_0000;
		while ((d & m) !== m) apb(1'b0, a, 32'h0000_0000, d);
	endtask : poll
	task automatic wait_frames(input int n);
		while (frames < n) @(posedge pclk);
	endtask : wait_frames
	function automatic logic [11:0] frame_of(input logic [7:0] lc, input logic [7:0] v,
		output int n);
		logic p;
		frame_of = 12'h000;
		p = 1'b0;
		n = 5 + lc[1:0];
		for (int i = 0; i < n; i++) begin
			frame_of[1 + i] = v[i];
			p ^= v[i];
		end
		p = lc[5] ? ~lc[4] : (lc[4] ? p : ~p);
		n++;
		if (lc[3]) frame_of[n++] = p;
		frame_of[n++] = 1'b1;
		if (lc[2]) frame_of[n++] = 1'b1;
	endfunction : frame_of
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdm(uart_frac_pkg::OFS_FRACTION, '1, 32'h0000_0000);
		rdm(uart_frac_pkg::OFS_DIVISOR, '1, 32'h0000_0001);
		rdm(uart_frac_pkg::OFS_LINE_CTL, '1, 32'h0000_0003);
		rdm(uart_frac_pkg::OFS_GAP, '1, 32'h0000_0000);
		rdm(uart_frac_pkg::OFS_LINE_ST, '1, 32'h0000_0060);
		rdm(8'h10, '1, 32'h0000_0000);
		wr(uart_frac_pkg::OFS_FRACTION, 32'h0000_01A5);
		rdm(uart_frac_pkg::OFS_FRACTION, '1, 32'h0000_00A5);
		wr(uart_frac_pkg::OFS_FRACTION, 32'h0000_0000);
		wr(uart_frac_pkg::OFS_DIVISOR, 32'h0000_0002);
		$display("test registers done");
		for (int k = 0; k < 5; k++) begin
			wr(uart_frac_pkg::OFS_LINE_CTL, {24'h0, LCS[k]});
			bits = frame_of(LCS[k], TXB[k], nb);
			nbits = nb;
			wr(uart_frac_pkg::OFS_DATA, {24'h0, TXB[k]});
			wait_frames(k + 1);
			chk({20'h0, frame_bits}, {20'h0, bits});
			poll(uart_frac_pkg::OFS_LINE_ST, 32'h40);
		end
		$display("test formats done");
		wr(uart_frac_pkg::OFS_LINE_CTL, 32'h0000_0003);
		nbits = 10;
		for (int k = 0; k < 4; k++) begin
			wr(uart_frac_pkg::OFS_GAP, GP[k]);
			wr(uart_frac_pkg::OFS_FRACTION, FR[k]);
			bit_cycles = BC[k];
			f0 = frames;
			wr(uart_frac_pkg::OFS_DATA, 32'h0000_0055);
			poll(uart_frac_pkg::OFS_LINE_ST, 32'h20);
			chk(d & 32'h40, 32'h0000_0000);
			wr(uart_frac_pkg::OFS_DATA, 32'h0000_00AA);
			// Frame one starts at an arbitrary tick phase
			poll(uart_frac_pkg::OFS_LINE_ST, 32'h20);
			wr(uart_frac_pkg::OFS_DATA, 32'h0000_005A);
			wait_frames(f0 + 2);
			t0 = frame_start;
			wait_frames(f0 + 3);
			chk(frame_start - t0, (10 + GP[k]) * BC[k]);
			poll(uart_frac_pkg::OFS_LINE_ST, 32'h40);
		end
		wr(uart_frac_pkg::OFS_FRACTION, 32'h0000_0000);
		wr(uart_frac_pkg::OFS_GAP, 32'h0000_0000);
		bit_cycles = 32;
		$display("test timing done");
		wr(uart_frac_pkg::OFS_LINE_CTL, 32'h0000_000B);
		wr(uart_frac_pkg::OFS_IRQ_EN, 32'h0000_0005);
		for (int k = 0; k < 3; k++) begin
			bits = frame_of(8'h0B, RXB[k], nb) ^ RXM[k];
			remote.send(bits, nb);
			while (irq !== 1'b1) @(posedge pclk);
			rdm(uart_frac_pkg::OFS_LINE_ST, '1, RST[k]);
			rdm(uart_frac_pkg::OFS_DATA, '1, {24'h0, RXB[k]});
			repeat (2) @(posedge pclk);
			chk({31'h0, irq}, 32'h0000_0000);
		end
		$display("test receive done");
		wr(uart_frac_pkg::OFS_LINE_CTL, 32'h0000_0003);
		wr(uart_frac_pkg::OFS_IRQ_EN, 32'h0000_0010);
		wr(uart_frac_pkg::OFS_TXD_ADDR, 32'h0000_0100);
		wr(uart_frac_pkg::OFS_TXD_CNT, 32'h0000_0003);
		remote.log_q.delete();
		f0 = frames;
		wr(uart_frac_pkg::OFS_DMA_CTL, 32'h0000_0001);
		poll(uart_frac_pkg::OFS_IRQ_ID, 32'h10);
		chk(frames - f0, 1);
		rdm(uart_frac_pkg::OFS_TXD_CNT, '1, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		wait_frames(f0 + 3);
		for (int k = 0; k < 3; k++) chk({24'h0, remote.log_q[k][8:1]}, {24'h0, txq[k]});
		wr(uart_frac_pkg::OFS_IRQ_ID, 32'h0000_0010);
		rdm(uart_frac_pkg::OFS_IRQ_ID, 32'h10, 32'h0000_0000);
		wr(uart_frac_pkg::OFS_DMA_CTL, 32'h0000_0000);
		$display("test dma transmit done");
		wr(uart_frac_pkg::OFS_IRQ_EN, 32'h0000_0020);
		wr(uart_frac_pkg::OFS_RXD_ADDR, 32'h8000_0200);
		rdm(uart_frac_pkg::OFS_RXD_ADDR, '1, 32'h8000_0200);
		wr(uart_frac_pkg::OFS_RXD_CNT, 32'h0000_0002);
		wr(uart_frac_pkg::OFS_DMA_CTL, 32'h0000_0002);
		bits = frame_of(8'h03, 8'h81, nb);
		remote.send(bits, nb);
		while (rxq.size() < 1) @(posedge pclk);
		rdm(uart_frac_pkg::OFS_IRQ_ID, 32'h20, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		bits = frame_of(8'h03, 8'h7E, nb);
		remote.send(bits, nb);
		while (irq !== 1'b1) @(posedge pclk);
		chk({rxq[0], rxq[1]}, 32'h0000_817E);
		chk(aq[0], 32'h8000_0202);
		chk(aq[1], 32'h8000_0201);
		rdm(uart_frac_pkg::OFS_RXD_CNT, '1, 32'h0000_0000);
		$display("test dma receive done");
		end_sim();
	end
endmodule : uart_frac_baud_dma_bench
`default_nettype wire
